// [core/psc_config_port.sv]
// Purpose: device side of a passive serial configuration port
// Assumes: host clock and pins are asynchronous, sampled by clock
// Notes: bitstream length is a top parameter in bytes
// Behaviour
// RULE1 - In user mode the request, status and done lines all stand high.
// RULE2 - A low request line takes the device out of user mode into a new configuration cycle.
// RULE3 - After power-up the status line is held low for the whole power-on delay.
// RULE4 - The done line is low from power-up, before and throughout configuration.
// RULE5 - The host keeps the serial clock at a fixed level after configuration.
// RULE6 - After configuration the data pin is released as a general-purpose pin.
// RULE7 - The host sends the complete bitstream with nothing left out.
// RULE8 - The done line is released high only after all data has arrived.
// RULE9 - The host gives two falling serial clock edges after done to start initialization.
// RULE10 - When enabled, the init-complete output stays low until initialization ends.
// RULE11 - Data is sampled on each rising serial clock edge, least significant bit first.
// RULE12 - The host waits for status high before clocking and restarts if status drops. The host model waits but never watches status while clocking.
`include "psc_regs.svh"

module psc_config_port #(
    parameter logic [`PSC_LEN_W-1:0] BITSTREAM_BYTES = `PSC_DEFAULT_LEN,
    parameter logic [`PSC_CNT_W-1:0] POR_CYCLES = `PSC_CNT_W'(`PSC_POR_CYCLES),
    parameter logic [`PSC_CNT_W-1:0] STATUS_CYCLES = `PSC_CNT_W'(`PSC_STATUS_CYCLES)
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic config_request_n,
    input wire logic config_serial_clock,
    input wire logic config_serial_data,
    input wire logic init_done_enable,
    output logic config_status_n_out,
    output logic config_status_n_oe_n,
    output logic config_done_out,
    output logic config_done_oe_n,
    output logic init_done_out,
    output logic init_done_oe_n,
    output logic user_io_release,
    output logic [7:0] cfg_byte,
    output logic cfg_byte_valid,
    output logic user_mode
);
    // two-stage synchronisers; the first stage feeds only the second
    logic [1:0] req_sync;
    logic [1:0] sck_sync;
    logic [1:0] dat_sync;
    logic sck_prev;

    always_ff @(posedge clock)
    begin
        req_sync <= {req_sync[0], config_request_n};
        sck_sync <= {sck_sync[0], config_serial_clock};
        dat_sync <= {dat_sync[0], config_serial_data};
        sck_prev <= sck_sync[1];
    end

    wire logic req_n = req_sync[1];
    wire logic sck_rise = sck_sync[1] & ~sck_prev;
    wire logic sck_fall = ~sck_sync[1] & sck_prev;

    psc_pkg::psc_state_t state;
    psc_pkg::psc_state_t next_state;
    logic [`PSC_CNT_W-1:0] cnt;
    logic [`PSC_CNT_W-1:0] next_cnt;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [`PSC_BIT_IDX_W-1:0] bit_idx;
    logic [`PSC_BIT_IDX_W-1:0] next_bit_idx;
    logic [`PSC_LEN_W-1:0] bytes;
    logic [`PSC_LEN_W-1:0] next_bytes;
    logic [1:0] edges;
    logic [1:0] next_edges;
    logic init_en;
    logic next_init_en;
    logic [7:0] next_cfg_byte;
    logic next_cfg_byte_valid;

    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_shreg = shreg;
        next_bit_idx = bit_idx;
        next_bytes = bytes;
        next_edges = edges;
        next_init_en = init_en;
        next_cfg_byte = cfg_byte;
        next_cfg_byte_valid = 1'b0;
        unique case (state)
            psc_pkg::PSC_ST_POR:
            begin
                // status held low for the whole power-on delay [RULE3]
                if (cnt >= POR_CYCLES - 1'b1)
                begin
                    next_state = psc_pkg::PSC_ST_RESET;
                    next_cnt = '0;
                end
                else
                begin
                    next_cnt = cnt + 1'b1;
                end
            end
            psc_pkg::PSC_ST_RESET:
            begin
                // a held-low request line keeps the device in reset [RULE2]
                if (req_n)
                begin
                    next_state = psc_pkg::PSC_ST_STATUS;
                    next_cnt = '0;
                end
            end
            psc_pkg::PSC_ST_STATUS:
            begin
                if (!req_n)
                begin
                    next_state = psc_pkg::PSC_ST_RESET;
                end
                else if (cnt >= STATUS_CYCLES - 1'b1)
                begin
                    next_state = psc_pkg::PSC_ST_LOAD;
                    next_bit_idx = '0;
                    next_bytes = '0;
                    next_init_en = init_done_enable;
                end
                else
                begin
                    next_cnt = cnt + 1'b1;
                end
            end
            psc_pkg::PSC_ST_LOAD:
            begin
                if (!req_n)
                begin
                    next_state = psc_pkg::PSC_ST_RESET;
                end
                else if (sck_rise)
                begin
                    // lsb first, one bit per rising edge [RULE11]
                    next_shreg = {dat_sync[1], shreg[7:1]};
                    next_bit_idx = bit_idx + 1'b1;
                    if (bit_idx == `PSC_BYTE_LAST_BIT)
                    begin
                        next_cfg_byte = {dat_sync[1], shreg[7:1]};
                        next_cfg_byte_valid = 1'b1;
                        next_bytes = bytes + 1'b1;
                        // done only once every byte is in [RULE8]
                        if (bytes + 1'b1 == BITSTREAM_BYTES)
                        begin
                            next_state = psc_pkg::PSC_ST_INIT;
                            next_edges = '0;
                        end
                    end
                end
            end
            psc_pkg::PSC_ST_INIT:
            begin
                if (!req_n)
                begin
                    next_state = psc_pkg::PSC_ST_RESET;
                end
                else if (sck_fall)
                begin
                    // first fall only closes the last data bit, so two more must follow [RULE9]
                    if (edges == `PSC_INIT_EDGES)
                    begin
                        next_state = psc_pkg::PSC_ST_USER;
                    end
                    else
                    begin
                        next_edges = edges + 1'b1;
                    end
                end
            end
            psc_pkg::PSC_ST_USER:
            begin
                // request low leaves user mode [RULE2]
                if (!req_n)
                begin
                    next_state = psc_pkg::PSC_ST_RESET;
                end
            end
            default:
            begin
                next_state = psc_pkg::PSC_ST_POR;
                next_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state <= psc_pkg::PSC_ST_POR;
            cnt <= '0;
            shreg <= '0;
            bit_idx <= '0;
            bytes <= '0;
            edges <= '0;
            init_en <= 1'b0;
            cfg_byte <= '0;
            cfg_byte_valid <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            shreg <= next_shreg;
            bit_idx <= next_bit_idx;
            bytes <= next_bytes;
            edges <= next_edges;
            init_en <= next_init_en;
            cfg_byte <= next_cfg_byte;
            cfg_byte_valid <= next_cfg_byte_valid;
        end
    end

    // pin drivers registered; oe_n low means driving, open drain pulls low only
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            config_status_n_out <= 1'b0;
            config_status_n_oe_n <= 1'b0;
            config_done_out <= 1'b0;
            config_done_oe_n <= 1'b0;
            init_done_out <= 1'b0;
            init_done_oe_n <= 1'b1;
            user_io_release <= 1'b0;
            user_mode <= 1'b0;
        end
        else
        begin
            config_status_n_out <= 1'b0;
            // status released once the hold-off ends [RULE3] [RULE1]
            config_status_n_oe_n <= (next_state == psc_pkg::PSC_ST_LOAD)
                || (next_state == psc_pkg::PSC_ST_INIT)
                || (next_state == psc_pkg::PSC_ST_USER);
            config_done_out <= 1'b0;
            // done low until the whole stream is in [RULE4] [RULE8] [RULE1]
            config_done_oe_n <= (next_state == psc_pkg::PSC_ST_INIT)
                || (next_state == psc_pkg::PSC_ST_USER);
            init_done_out <= 1'b0;
            // driven low only when enabled and in the init state, released otherwise [RULE10]
            init_done_oe_n <= !(next_init_en && next_state == psc_pkg::PSC_ST_INIT);
            // data pin handed to user logic after configuration [RULE6]
            user_io_release <= next_state == psc_pkg::PSC_ST_USER;
            user_mode <= next_state == psc_pkg::PSC_ST_USER;
        end
    end
endmodule

// [core/psc_pkg.sv]
// Purpose: types for the passive serial config port
// Assumes: nothing beyond the regs header
// Notes: one-hot state codes
package psc_pkg;
    typedef enum logic [5:0] {
        PSC_ST_POR     = 6'h01,
        PSC_ST_RESET   = 6'h02,
        PSC_ST_STATUS  = 6'h04,
        PSC_ST_LOAD    = 6'h08,
        PSC_ST_INIT    = 6'h10,
        PSC_ST_USER    = 6'h20
    } psc_state_t;
endpackage

// [core/psc_regs.svh]
// Purpose: timing and layout constants for the passive serial config port
// Assumes: system clock of 10 MHz (100 ns period)
// Notes: times in their own unit, cycle counts derived from them
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH

`define PSC_CLK_PERIOD_NS 100
// power-on hold-off of the status line (status low pulse, in us)
`define PSC_POR_DELAY_US 268
`define PSC_POR_CYCLES (((`PSC_POR_DELAY_US * 1000) + `PSC_CLK_PERIOD_NS - 1) / `PSC_CLK_PERIOD_NS)
// status low time after a request release
`define PSC_STATUS_LOW_US 268
`define PSC_STATUS_CYCLES (((`PSC_STATUS_LOW_US * 1000) + `PSC_CLK_PERIOD_NS - 1) / `PSC_CLK_PERIOD_NS)
`define PSC_CNT_W 16
`define PSC_BIT_IDX_W 3
`define PSC_BYTE_LAST_BIT 3'h7
// falling edges of the serial clock needed after done
`define PSC_INIT_EDGES 2'h2
`define PSC_LEN_W 24
`define PSC_DEFAULT_LEN 24'h000010

`endif

// [dv/psc_config_port_monitor.sv]
// Purpose: concurrent checks on the passive serial config port pins
// Assumes: one clock domain, srst synchronous and active high
// Notes: byte count before done is judged by the bench, not here
module psc_config_port_monitor (
    input wire logic clock,
    input wire logic srst,
    input wire logic config_request_n,
    input wire logic config_status_n_oe_n,
    input wire logic config_done_oe_n,
    input wire logic init_done_oe_n,
    input wire logic user_io_release,
    input wire logic cfg_byte_valid,
    input wire logic user_mode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    property p_user; user_mode |-> config_status_n_oe_n && config_done_oe_n; endproperty
    a_user: assert property (p_user) else $error("line low in user mode");
    // four cycles covers the request synchroniser plus the state register
    property p_req; !config_request_n [*4] |=> !user_mode && !config_done_oe_n; endproperty
    a_req: assert property (p_req) else $error("request low ignored");
    property p_por; $fell(srst) |-> !config_status_n_oe_n [*8]; endproperty
    a_por: assert property (p_por) else $error("status released early");
    property p_done; !config_status_n_oe_n |-> !config_done_oe_n; endproperty
    a_done: assert property (p_done) else $error("done high while status low");
    property p_io; user_mode |-> user_io_release; endproperty
    a_io: assert property (p_io) else $error("data pin kept in user mode");
    property p_entry; $rose(user_mode) |-> $past(config_done_oe_n, 6); endproperty
    a_entry: assert property (p_entry) else $error("user mode too soon");
    property p_init; !init_done_oe_n |-> !user_mode; endproperty
    a_init: assert property (p_init) else $error("init line low in user mode");
    property p_byte; cfg_byte_valid |=> !cfg_byte_valid [*8]; endproperty
    a_byte: assert property (p_byte) else $error("byte pulses too close");
endmodule

bind psc_config_port psc_config_port_monitor psc_config_port_monitor_inst (
    .clock(clock), .srst(srst), .config_request_n(config_request_n),
    .config_status_n_oe_n(config_status_n_oe_n), .config_done_oe_n(config_done_oe_n),
    .init_done_oe_n(init_done_oe_n), .user_io_release(user_io_release),
    .cfg_byte_valid(cfg_byte_valid), .user_mode(user_mode));

// [dv/psc_config_port_tb.sv]
// Purpose: self-checking bench for the passive serial config port
// Assumes: host model paces the serial clock
// Notes: short hold-off counts and a two byte stream keep the run brief
module psc_config_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, srst, init_done_enable, st_oe_n, st_out, dn_oe_n, dn_out, in_oe_n, in_out;
    logic req_n, sclk, sdata, io_rel, byte_valid, user_mode;
    logic [7:0] cfg_byte;
    logic [7:0] got_q[$];
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    wire status_n = st_oe_n ? 1'b1 : st_out;
    wire done = dn_oe_n ? 1'b1 : dn_out;
    wire init_n = in_oe_n ? 1'b1 : in_out;
    psc_config_port #(.BITSTREAM_BYTES(24'h000002), .POR_CYCLES(16'h0014),
        .STATUS_CYCLES(16'h0014)) psc_config_port_inst (.clock(clock), .srst(srst),
        .config_request_n(req_n), .config_serial_clock(sclk), .config_serial_data(sdata),
        .init_done_enable(init_done_enable), .config_status_n_out(st_out),
        .config_status_n_oe_n(st_oe_n), .config_done_out(dn_out), .config_done_oe_n(dn_oe_n),
        .init_done_out(in_out), .init_done_oe_n(in_oe_n), .user_io_release(io_rel),
        .cfg_byte(cfg_byte), .cfg_byte_valid(byte_valid), .user_mode(user_mode));
    psc_host_model psc_host_model_inst (.clock(clock), .config_status_n(status_n),
        .config_request_n(req_n), .config_serial_clock(sclk), .config_serial_data(sdata));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic t_load(input logic [7:0] a, input logic [7:0] b, input logic en);
        init_done_enable <= en;
        got_q.delete();
        psc_host_model_inst.wait_status();
        psc_host_model_inst.send_byte(a);
        chk({6'h0, done, init_n}, 8'h1);
        psc_host_model_inst.send_byte(b);
        repeat (4) @(posedge clock);
        chk({6'h0, done, init_n}, {6'h0, 1'b1, ~en});
        chk(got_q[0], a);
        chk(got_q[1], b);
        psc_host_model_inst.pulse();
        repeat (6) @(posedge clock);
        chk({7'h0, user_mode}, 8'h0);
        psc_host_model_inst.pulse();
        repeat (6) @(posedge clock);
        chk({6'h0, user_mode, io_rel}, 8'h3);
        chk({5'h0, status_n, done, init_n}, 8'h7);
    endtask
    // a dropped request mid-stream must discard the partial byte
    task automatic t_restart(input int bits);
        repeat (bits) psc_host_model_inst.send_bit(1'b1);
        psc_host_model_inst.set_request(1'b0);
        repeat (6) @(posedge clock);
        chk({5'h0, status_n, done, user_mode}, 8'h0);
        psc_host_model_inst.set_request(1'b1);
    endtask
    task automatic wrap_up();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clock)
        if (byte_valid === 1'b1)
            got_q.push_back(cfg_byte);
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            n_errors++;
            wrap_up();
        end
    end
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial
    begin
        srst = 1'b1;
        init_done_enable = 1'b0;
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        repeat (10) @(posedge clock);
        chk({6'h0, status_n, done}, 8'h0);
        t_load(8'ha5, 8'h3c, 1'b0);
        t_restart(0);
        psc_host_model_inst.wait_status();
        t_restart(5);
        t_load(8'h81, 8'h7e, 1'b1);
        wrap_up();
    end
endmodule

// [dv/psc_host_model.sv]
// Purpose: configuration host model driving the serial port
// Assumes: serial half period of 4 system clocks (800 ns period)
// Notes: serial clock stands low between frames
module psc_host_model (
    input wire logic clock,
    input wire logic config_status_n,
    output logic config_request_n,
    output logic config_serial_clock,
    output logic config_serial_data
);
    // idle host: request high, serial clock parked low
    initial
    begin
        config_request_n = 1'b1;
        config_serial_clock = 1'b0;
        config_serial_data = 1'b0;
    end
    task automatic pulse();
        repeat (4) @(posedge clock);
        config_serial_clock <= 1'b1;
        repeat (4) @(posedge clock);
        config_serial_clock <= 1'b0;
    endtask
    task automatic send_bit(input logic b);
        config_serial_data <= b;
        pulse();
    endtask
    // the line is scrambled after a byte so a stale bit never passes for data
    task automatic send_byte(input logic [7:0] v);
        for (int i = 0; i < 8; i++)
            send_bit(v[i]);
        @(posedge clock);
        config_serial_data <= ~config_serial_data;
        // one edge passes so the next bit never lands in the same step
        @(posedge clock);
    endtask
    task automatic set_request(input logic v);
        @(posedge clock);
        config_request_n <= v;
    endtask
    task automatic wait_status();
        repeat (200) if (config_status_n !== 1'b1) @(posedge clock);
        repeat (3) @(posedge clock);
    endtask
endmodule
